// file: hdl/wukc_gate.sv
/*
 * wukc_gate: write unlock key registers, key compare and write gate
 * for the protected register set, with an APB slave port.
 * Assumes stored_key and key_check_enable come from the configuration
 * mirror on the same clock, and prot_wr_req from the host write path.
 */
// Local design decision: the APB register port.
`timescale 1ns/100ps
module wukc_gate
  import wukc_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = int'(FIRST_REFRESH_CYC)
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // configuration mirror
  input  wire logic [31:0]       stored_key,
  input  wire logic [7:0]        key_check_enable,
  // protected write path
  input  wire logic              prot_wr_req,
  output logic                   prot_wr_ok
);

  localparam int unsigned CNT_W = $clog2(REFRESH_CYCLES + 1);

  // elaboration-time parameter checks
  if (REFRESH_CYCLES < 1) begin : g_bad_refresh
    $error("REFRESH_CYCLES must be at least one");
  end
  if (APB_AW < 11) begin : g_bad_aw
    $error("APB_AW must leave address bits above the word index");
  end

  function automatic logic [8:0] idx_of(input logic [APB_AW-1:0] a);
    // bit 8 flags a misaligned or out-of-window address, so no key byte aliases
    idx_of = {(a[1:0] != 2'b00) || (a[APB_AW-1:10] != '0), a[9:2]};
  endfunction : idx_of

  function automatic logic key_hit(input logic [8:0] i);
    key_hit = (i == {1'b0, KEY_BYTE0_IDX}) || (i == {1'b0, KEY_BYTE1_IDX}) ||
              (i == {1'b0, KEY_BYTE2_IDX}) || (i == {1'b0, KEY_BYTE3_IDX});
  endfunction : key_hit

  logic [31:0]      key_ff,       nxt_key;
  logic [CNT_W-1:0] cnt_ff,       nxt_cnt;
  logic             refreshed_ff, nxt_refreshed;
  logic [31:0]      rdata_ff,     nxt_rdata;
  logic             err_ff,       nxt_err;
  logic             wr_take;
  logic             unlocked;
  logic             clear_now;
  logic [8:0]       idx;

  assign idx       = idx_of(paddr);
  assign wr_take   = psel && penable && pwrite;
  assign clear_now = !refreshed_ff && (cnt_ff == CNT_W'(REFRESH_CYCLES - 1));

  assign unlocked   = (key_check_enable != KEY_CHECK_ON) ||
                      (key_ff == stored_key);
  assign prot_wr_ok = prot_wr_req && unlocked;

  // zero wait states: every transfer ends in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_ff;
  assign pslverr = err_ff;

  always_comb begin
    nxt_key       = key_ff;
    nxt_cnt       = cnt_ff;
    nxt_refreshed = refreshed_ff;
    if (!refreshed_ff) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
    if (wr_take) begin
      unique case (idx)
        {1'b0, KEY_BYTE0_IDX}: nxt_key[7:0]   = pwdata[7:0];
        {1'b0, KEY_BYTE1_IDX}: nxt_key[15:8]  = pwdata[7:0];
        {1'b0, KEY_BYTE2_IDX}: nxt_key[23:16] = pwdata[7:0];
        {1'b0, KEY_BYTE3_IDX}: nxt_key[31:24] = pwdata[7:0];
        default: ;
      endcase
    end
    // clear beats a key write landing in the same cycle
    if (clear_now) begin
      nxt_key       = KEY_RESET;
      nxt_refreshed = 1'b1;
    end
  end

  // read data and error captured in the setup cycle
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    if (psel && !penable) begin
      unique case (idx)
        {1'b0, KEY_BYTE0_IDX},
        {1'b0, KEY_BYTE1_IDX},
        {1'b0, KEY_BYTE2_IDX},
        {1'b0, KEY_BYTE3_IDX}: nxt_rdata = 32'h0000_0000;
        {1'b0, GATE_STATUS_IDX}: begin
          nxt_rdata[ST_UNLOCKED_BIT]  = unlocked;
          nxt_rdata[ST_REFRESHED_BIT] = refreshed_ff;
          nxt_rdata[ST_CHECK_ON_BIT]  = key_check_enable == KEY_CHECK_ON;
          nxt_err                     = pwrite;
        end
        default: nxt_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_ff       <= KEY_RESET;
      cnt_ff       <= '0;
      refreshed_ff <= 1'b0;
      rdata_ff     <= 32'h0000_0000;
      err_ff       <= 1'b0;
    end else begin
      key_ff       <= nxt_key;
      cnt_ff       <= nxt_cnt;
      refreshed_ff <= nxt_refreshed;
      rdata_ff     <= nxt_rdata;
      err_ff       <= nxt_err;
    end
  end

  // reference age counter for the refresh check, saturates at REFRESH_CYCLES
  logic [CNT_W-1:0] age_ff, nxt_age;

  always_comb begin
    nxt_age = age_ff;
    if (age_ff != CNT_W'(REFRESH_CYCLES)) begin
      nxt_age = age_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_ff <= '0;
    end else begin
      age_ff <= nxt_age;
    end
  end

  // checks
  sequence s_key_read_setup;
    psel && !penable && !pwrite && key_hit(idx);
  endsequence

  sequence s_key_read_answer;
    psel && penable && (prdata == '0) && !pslverr;
  endsequence

  sequence s_byte1_write;
    wr_take && (idx == {1'b0, KEY_BYTE1_IDX}) && !clear_now;
  endsequence

  chk_key_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(refreshed_ff) |-> (key_ff == KEY_RESET))
    else $error("key not cleared after first refresh");

  chk_gate_locked: assert property (@(posedge clk) disable iff (!rst_n)
    (prot_wr_req && key_check_enable == KEY_CHECK_ON && key_ff != stored_key)
      |-> !prot_wr_ok)
    else $error("protected write passed with wrong key");

  chk_gate_scope: assert property (@(posedge clk) disable iff (!rst_n)
    !prot_wr_req |-> !prot_wr_ok)
    else $error("grant without a protected write request");

  chk_gate_match: assert property (@(posedge clk) disable iff (!rst_n)
    (prot_wr_req && key_ff == stored_key) |-> prot_wr_ok)
    else $error("matching key did not unlock");

  chk_byte_place: assert property (@(posedge clk) disable iff (!rst_n)
    s_byte1_write |=> (key_ff[15:8] == $past(pwdata[7:0])) && $stable(key_ff[7:0]))
    else $error("key byte one landed in the wrong lane");

  chk_wo_read: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && penable && !pwrite && key_hit(idx))
      |-> (prdata == '0))
    else $error("key register read returned data");

  chk_gate_free: assert property (@(posedge clk) disable iff (!rst_n)
    (prot_wr_req && key_check_enable != KEY_CHECK_ON) |-> prot_wr_ok)
    else $error("protected write blocked with check disabled");

  chk_refresh_time: assert property (@(posedge clk) disable iff (!rst_n)
    refreshed_ff == (age_ff == CNT_W'(REFRESH_CYCLES)))
    else $error("first refresh clear at the wrong cycle");

  chk_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
    clear_now |=> (key_ff == KEY_RESET))
    else $error("key write survived the refresh clear");

  chk_key_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!wr_take && !clear_now) |=> $stable(key_ff))
    else $error("key changed without a write");

  chk_wo_noerr: assert property (@(posedge clk) disable iff (!rst_n)
    s_key_read_setup |=> s_key_read_answer)
    else $error("key register read answered with data or error");

  chk_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable && pwrite && idx == {1'b0, GATE_STATUS_IDX}) |=> pslverr)
    else $error("write to status register not refused");

  chk_err_phase: assert property (@(posedge clk) disable iff (!rst_n)
    pslverr |-> (psel && penable))
    else $error("error flagged outside an access phase");

endmodule : wukc_gate

// file: pkg/wukc_pkg.sv
/*
 * wukc_pkg: constants for the write unlock key check block.
 * Assumes a 40 MHz core clock and a 32-bit APB register port.
 */
package wukc_pkg;
  localparam int unsigned APB_AW           = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0]  KEY_BYTE0_IDX    = 8'h39;
  localparam logic [7:0]  KEY_BYTE1_IDX    = 8'h3a;
  localparam logic [7:0]  KEY_BYTE2_IDX    = 8'h3b;
  localparam logic [7:0]  KEY_BYTE3_IDX    = 8'h3c;
  localparam logic [7:0]  GATE_STATUS_IDX  = 8'h40;
  // status field positions
  localparam int unsigned ST_UNLOCKED_BIT  = 0;
  localparam int unsigned ST_REFRESHED_BIT = 1;
  localparam int unsigned ST_CHECK_ON_BIT  = 2;
  // reset value and check enable code
  localparam logic [31:0] KEY_RESET        = 32'h0000_0000;
  localparam logic [7:0]  KEY_CHECK_ON     = 8'hff;
  // first refresh interval
  localparam longint      FIRST_REFRESH_MS = 66;
  localparam longint      CLK_HZ           = 40_000_000;
  localparam longint      FIRST_REFRESH_CYC = (FIRST_REFRESH_MS * CLK_HZ) / 1000;
endpackage : wukc_pkg

// file: tb/wukc_gate_tb_top.sv
/* wukc_gate_tb_top: self-checking bench for the unlock key gate, apb master and gate checks.
   the master waits for pready; assumes a short refresh count in simulation. */
`timescale 1ns/100ps
module wukc_gate_tb_top;
  import wukc_pkg::*;
  localparam int unsigned RC = 20;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic              prot_wr_req, prot_wr_ok;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, stored_key, key, rd;
  logic [7:0]        key_check_enable;
  int                n_fail, samples_checked;

  wukc_gate #(.REFRESH_CYCLES(RC)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stored_key(stored_key),
    .key_check_enable(key_check_enable), .prot_wr_req(prot_wr_req), .prot_wr_ok(prot_wr_ok));

  function automatic logic exp_ok(logic req, logic [7:0] en, logic [31:0] k, logic [31:0] st);
    return req && (en != KEY_CHECK_ON || k == st);
  endfunction : exp_ok

  function automatic logic [31:0] exp_status(logic [7:0] en, logic [31:0] k, logic [31:0] st,
                                             logic done);
    logic [31:0] s;
    s                   = '0;
    s[ST_UNLOCKED_BIT]  = exp_ok(1'b1, en, k, st);
    s[ST_REFRESHED_BIT] = done;
    s[ST_CHECK_ON_BIT]  = en == KEY_CHECK_ON;
    return s;
  endfunction : exp_status

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic cmp_bit(string name, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  // one apb transfer; pready, read data and error taken at the same rising edge
  task automatic apb(logic wr, logic [7:0] idx, logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q   = prdata;
    err = pslverr;
    if (i >= 50) begin
      n_fail++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic write_key(logic [31:0] k);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, 8'(KEY_BYTE0_IDX + b), {24'($urandom), k[8*b +: 8]}, rd);
    end
  endtask : write_key

  task automatic gate(logic req, logic [7:0] en, logic [31:0] st);
    @(posedge clk);
    prot_wr_req      <= req;
    key_check_enable <= en;
    stored_key       <= st;
    @(negedge clk);
    cmp_bit("prot_wr_ok", exp_ok(req, en, key, st), prot_wr_ok);
  endtask : gate

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n            = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = '0;
    pwdata           = '0;
    stored_key       = '0;
    key_check_enable = KEY_CHECK_ON;
    prot_wr_req      = 1'b0;
    key              = '0;
    err              = 1'b0;
    n_fail           = 0;
    samples_checked  = 0;
    void'($urandom(17404));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, KEY_BYTE0_IDX, 32'hffff_ff5a, rd);
    key[7:0] = 8'h5a;
    gate(1'b1, KEY_CHECK_ON, 32'h0000_0000);
    apb(1'b0, GATE_STATUS_IDX, 32'h0000_0000, rd);
    cmp("status", exp_status(KEY_CHECK_ON, key, 32'h0000_0000, 1'b0), rd);
    repeat (RC) @(posedge clk);
    key = '0;
    gate(1'b1, KEY_CHECK_ON, 32'h0000_0000);
    apb(1'b0, GATE_STATUS_IDX, 32'h0000_0000, rd);
    cmp("status", exp_status(KEY_CHECK_ON, key, 32'h0000_0000, 1'b1), rd);
    $display("test refresh clear done");
    apb(1'b1, GATE_STATUS_IDX, 32'hffff_ffff, rd);
    cmp_bit("status write pslverr", 1'b1, err);
    apb(1'b0, 8'h41, 32'h0000_0000, rd);
    cmp_bit("unmapped read pslverr", 1'b1, err);
    cmp("unmapped read data", 32'h0000_0000, rd);
    $display("test error responses done");
    repeat (20) begin
      key = $urandom;
      write_key(key);
      gate(1'b1, KEY_CHECK_ON, key);
      gate(1'b1, KEY_CHECK_ON, key ^ (32'h0000_0001 << ($urandom % 32)));
      gate(1'b0, KEY_CHECK_ON, key);
      gate(1'b1, 8'($urandom % 255), ~key);
      apb(1'b0, 8'(KEY_BYTE0_IDX + $urandom % 4), 32'h0000_0000, rd);
      cmp("key byte read", 32'h0000_0000, rd);
      cmp_bit("key byte read pslverr", 1'b0, err);
    end
    $display("test random keys done");
    key = 32'h1234_5678;
    write_key(key);
    gate(1'b1, KEY_CHECK_ON, 32'h1234_5678);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    key = '0;
    gate(1'b1, KEY_CHECK_ON, 32'h1234_5678);
    apb(1'b0, GATE_STATUS_IDX, 32'h0000_0000, rd);
    cmp("status", exp_status(KEY_CHECK_ON, key, 32'h1234_5678, 1'b0), rd);
    repeat (RC) @(posedge clk);
    gate(1'b1, KEY_CHECK_ON, 32'h0000_0000);
    apb(1'b0, GATE_STATUS_IDX, 32'h0000_0000, rd);
    cmp("status", exp_status(KEY_CHECK_ON, key, 32'h0000_0000, 1'b1), rd);
    $display("test reset and status done");
    conclude();
  end
endmodule : wukc_gate_tb_top
